// [hdl/sssx_bcd_sub.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Packed BCD byte subtract: two digits with borrow chain
// ---------------------------------------------------------------
module sssx_bcd_sub (
  // Operands
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       borrow_in,
  // Result
  output logic      [7:0] diff,
  output logic            borrow_out
);

  wire logic [4:0] lo_raw = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
  wire logic       lo_brw = lo_raw[4];
  wire logic [4:0] hi_raw = {1'b0, minuend[7:4]} - {1'b0, subtrahend[7:4]} - {4'h0, lo_brw};

  // A negative digit is pulled back into 0..9 by taking 6 more
  // Each digit is corrected by its own borrow, not by its neighbour's
  assign diff       = {hi_raw[4] ? 4'(hi_raw[3:0] - 4'h6) : hi_raw[3:0],
                       lo_brw ? 4'(lo_raw[3:0] - 4'h6) : lo_raw[3:0]};
  assign borrow_out = hi_raw[4];

endmodule // sssx_bcd_sub

// [hdl/sssx_exec.sv]
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Logical shift by one moves right, zero enters top, bit 0 goes to carry.
// - Shift by one sets overflow when the sign bit changes, else clears it.
// - Logical shift by count repeats the one-place step count times.
// - Sign-fill shift by one keeps the top bit, bit 0 goes to carry.
// - Sign-fill shift by count repeats; last outgoing bit stays in carry.
// - Block store writes accumulator low byte or full word at the pointer.
// - Pointer moves by one for bytes, two for words, after each store.
// - Direction flag clear increments the pointer, set decrements it.
// - Generic store form uses width bit; byte and word forms are fixed.
// - Block store always addresses the extra segment, override ignored.
// - Subtract source from destination into the result register, update six flags.
// - Borrow subtract also takes away carry; six flags from the result.
// - Decimal string subtract: destination string minus source string, into destination.
// - Digit count comes from the count register, 1 to 255 digits.
// - Decimal destination in extra segment; source default data segment, overridable.
// - Decimal strings run in whole bytes; odd counts act as next even.
module sssx_exec
  import sssx_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Operand memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic      [19:0] mem_addr,
  output logic      [1:0]  mem_be,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // Status
  output logic             busy
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [19:0] phys_addr(input logic [15:0] base, input logic [15:0] ofs);
    phys_addr = {base, 4'h0} + {4'h0, ofs};
  endfunction

  // Parity, sign and zero from a result of the chosen width
  function automatic logic [11:0] psz(input logic [11:0] f, input logic [15:0] r, input logic w);
    logic [11:0] o;
    o = f;
    o[FLG_PARITY] = ~^r[7:0];
    o[FLG_SIGN]   = w ? r[15] : r[7];
    o[FLG_ZERO]   = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
    psz = o;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  sssx_state_e state_reg;
  logic [2:0]  op_reg;
  logic        wide_reg;
  logic [15:0] dst_reg, src_reg, accum_reg, six_reg, dptr_reg, dseg_reg, xseg_reg;
  logic [16:0] ovr_reg;
  logic [7:0]  count_reg;
  logic [11:0] flags_reg;
  logic [15:0] result_reg;
  logic [7:0]  steps_reg;
  logic        first_sign_reg;
  logic [7:0]  bytes_left_reg;
  logic [15:0] byte_idx_reg;
  logic [7:0]  src_byte_reg;
  logic        borrow_reg;
  logic        nonzero_reg;
  logic        mem_req_reg, mem_we_reg;
  logic [19:0] mem_addr_reg;
  logic [1:0]  mem_be_reg;
  logic [15:0] mem_wdata_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic acc_phase = psel & penable & pready_reg;
  wire logic wr_ok     = acc_phase & pwrite & ~pslverr_reg & (state_reg == ST_IDLE);
  wire logic mapped    = (paddr[1:0] == 2'b00) && (paddr <= OFS_RESULT);
  wire logic wr_ctrl   = wr_ok & (paddr == OFS_CTRL);
  wire logic start     = wr_ctrl & pwdata[CTRL_START];
  wire logic [2:0] new_op = pwdata[CTRL_OP_LSB +: 3];
  wire logic [1:0] form   = pwdata[CTRL_FORM_LSB +: 2];

  // Store width from the form; generic follows the width bit
  wire logic store_wide = (form == FORM_WORDS) |
                          ((form == FORM_GENERIC) & pwdata[CTRL_WIDE]);
  wire logic op_wide    = (new_op == OP_STORE) ? store_wide : pwdata[CTRL_WIDE];

  wire logic [31:0] rd_mux =
    (paddr == OFS_CTRL)      ? {28'h0, wide_reg, op_reg} :
    (paddr == OFS_DST_OPND)  ? {16'h0, dst_reg} :
    (paddr == OFS_SRC_OPND)  ? {16'h0, src_reg} :
    (paddr == OFS_COUNT)     ? {24'h0, count_reg} :
    (paddr == OFS_ACCUM)     ? {16'h0, accum_reg} :
    (paddr == OFS_SRC_INDEX) ? {16'h0, six_reg} :
    (paddr == OFS_DST_PTR)   ? {16'h0, dptr_reg} :
    (paddr == OFS_DSEG)      ? {16'h0, dseg_reg} :
    (paddr == OFS_XSEG)      ? {16'h0, xseg_reg} :
    (paddr == OFS_OVERRIDE)  ? {15'h0, ovr_reg} :
    (paddr == OFS_STATUS)    ? {15'h0, state_reg != ST_IDLE, 4'h0, flags_reg} :
    (paddr == OFS_RESULT)    ? {16'h0, result_reg} : 32'h0;

  // Zero-wait APB: ready rises in the access phase after every setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~mapped;
      prdata_reg  <= (psel & ~penable & ~pwrite & mapped) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Datapath helpers
  // ---------------------------------------------------------------
  logic [15:0] step_val;
  logic        step_out;

  sssx_shift_step u_step (
    .value_in  (result_reg),
    .wide      (wide_reg),
    .sign_fill (op_reg == OP_ASHIFT),
    .value_out (step_val),
    .bit_out   (step_out)
  );

  logic [7:0] bcd_diff;
  logic       bcd_borrow;

  sssx_bcd_sub u_bcd (
    .minuend    (mem_rdata[7:0]),
    .subtrahend (src_byte_reg),
    .borrow_in  (borrow_reg),
    .diff       (bcd_diff),
    .borrow_out (bcd_borrow)
  );

  // Binary subtract with optional borrow-in, done at launch
  wire logic        cin      = (new_op == OP_BORROW_DIFFERENCE_OP) & flags_reg[FLG_CARRY];
  wire logic [16:0] sub_raw  = {1'b0, dst_reg} - {1'b0, src_reg} - {16'h0, cin};
  wire logic [15:0] sub_res  = op_wide ? sub_raw[15:0] : {8'h00, sub_raw[7:0]};
  wire logic [15:0] sub_x    = dst_reg ^ src_reg ^ sub_raw[15:0];
  // Byte borrow is the carry into bit 8, whatever the upper operand bytes hold
  wire logic        sub_cy   = op_wide ? sub_raw[16] : sub_x[8];
  wire logic [15:0] ov_vec   = (dst_reg ^ src_reg) & (dst_reg ^ sub_raw[15:0]);
  wire logic        sub_ov   = op_wide ? ov_vec[15] : ov_vec[7];

  logic [11:0] sub_flags;
  always_comb
  begin
    sub_flags               = psz(flags_reg, sub_res, op_wide);
    sub_flags[FLG_CARRY]    = sub_cy;
    sub_flags[FLG_AUX]      = sub_x[4];
    sub_flags[FLG_OVERFLOW] = sub_ov;
  end

  // Pointer step for a stored element
  wire logic [15:0] ptr_step = wide_reg ? 16'h0002 : 16'h0001;
  wire logic [15:0] ptr_next = flags_reg[FLG_DIR] ? dptr_reg - ptr_step
                                                  : dptr_reg + ptr_step;
  // Source segment honours an override; destination never does
  wire logic [15:0] src_seg  = ovr_reg[OVR_ENABLE] ? ovr_reg[15:0] : dseg_reg;
  // Odd digit counts round up to whole bytes
  wire logic [7:0]  nbytes   = 8'((9'(count_reg) + 9'h001) >> 1);
  wire logic [15:0] idx_next = byte_idx_reg + 16'h0001;
  // Shift count of exactly one selects the defined-overflow case
  wire logic count_is_one = (src_reg[7:0] == 8'h01);

  // ---------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dst_reg   <= WORD_RST;
      src_reg   <= WORD_RST;
      accum_reg <= WORD_RST;
      six_reg   <= WORD_RST;
      dseg_reg  <= WORD_RST;
      xseg_reg  <= WORD_RST;
      ovr_reg   <= 17'h0;
      count_reg <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (paddr == OFS_DST_OPND)  dst_reg   <= pwdata[15:0];
      if (paddr == OFS_SRC_OPND)  src_reg   <= pwdata[15:0];
      if (paddr == OFS_ACCUM)     accum_reg <= pwdata[15:0];
      if (paddr == OFS_SRC_INDEX) six_reg   <= pwdata[15:0];
      if (paddr == OFS_DSEG)      dseg_reg  <= pwdata[15:0];
      if (paddr == OFS_XSEG)      xseg_reg  <= pwdata[15:0];
      if (paddr == OFS_OVERRIDE)  ovr_reg   <= pwdata[16:0];
      if (paddr == OFS_COUNT)     count_reg <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer: shifts one place a cycle, memory ops via handshake
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg      <= ST_IDLE;
      op_reg         <= OP_LSHIFT;
      wide_reg       <= 1'b0;
      flags_reg      <= FLAGS_RST;
      result_reg     <= WORD_RST;
      dptr_reg       <= WORD_RST;
      steps_reg      <= 8'h00;
      first_sign_reg <= 1'b0;
      bytes_left_reg <= 8'h00;
      byte_idx_reg   <= WORD_RST;
      src_byte_reg   <= 8'h00;
      borrow_reg     <= 1'b0;
      nonzero_reg    <= 1'b0;
      mem_req_reg    <= 1'b0;
      mem_we_reg     <= 1'b0;
      mem_addr_reg   <= 20'h0;
      mem_be_reg     <= 2'b00;
      mem_wdata_reg  <= WORD_RST;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (wr_ok & (paddr == OFS_DST_PTR))
            dptr_reg <= pwdata[15:0];
          if (wr_ok & (paddr == OFS_STATUS))
            flags_reg <= pwdata[11:0];
          if (start)
          begin
            op_reg   <= new_op;
            wide_reg <= op_wide;
            case (new_op)
              OP_LSHIFT, OP_ASHIFT:
              begin
                result_reg     <= op_wide ? dst_reg : {8'h00, dst_reg[7:0]};
                steps_reg      <= src_reg[7:0];
                first_sign_reg <= op_wide ? dst_reg[15] : dst_reg[7];
                if (src_reg[7:0] != 8'h00)
                  state_reg <= ST_SHIFT;
              end
              OP_SUB, OP_BORROW_DIFFERENCE_OP:
              begin
                result_reg <= sub_res;
                flags_reg  <= sub_flags;
              end
              OP_STORE:
              begin
                mem_req_reg   <= 1'b1;
                mem_we_reg    <= 1'b1;
                mem_addr_reg  <= phys_addr(xseg_reg, dptr_reg);
                mem_be_reg    <= store_wide ? 2'b11 : 2'b01;
                mem_wdata_reg <= store_wide ? accum_reg
                                            : {8'h00, accum_reg[7:0]};
                state_reg     <= ST_STORE;
              end
              OP_DECSUB:
              begin
                bytes_left_reg <= nbytes;
                byte_idx_reg   <= WORD_RST;
                borrow_reg     <= 1'b0;
                nonzero_reg    <= 1'b0;
                if (nbytes != 8'h00)
                begin
                  mem_req_reg  <= 1'b1;
                  mem_we_reg   <= 1'b0;
                  mem_be_reg   <= 2'b01;
                  mem_addr_reg <= phys_addr(src_seg, six_reg);
                  state_reg    <= ST_RDSRC;
                end
              end
              default:
                state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_SHIFT:
        begin
          result_reg <= step_val;
          steps_reg  <= steps_reg - 8'h01;
          flags_reg  <= psz(flags_reg, step_val, wide_reg);
          flags_reg[FLG_CARRY] <= step_out;
          // Overflow only defined for a single place; kept otherwise
          if (count_is_one)
            flags_reg[FLG_OVERFLOW] <= first_sign_reg ^
                                       (wide_reg ? step_val[15] : step_val[7]);
          if (steps_reg == 8'h01)
            state_reg <= ST_IDLE;
        end
        ST_STORE:
        begin
          // Flags are not touched on this path
          if (mem_ack)
          begin
            mem_req_reg <= 1'b0;
            mem_we_reg  <= 1'b0;
            dptr_reg    <= ptr_next;
            state_reg   <= ST_IDLE;
          end
        end
        ST_RDSRC:
        begin
          if (mem_ack)
          begin
            src_byte_reg <= mem_rdata[7:0];
            mem_addr_reg <= phys_addr(xseg_reg, dptr_reg + byte_idx_reg);
            state_reg    <= ST_RDDST;
          end
        end
        ST_RDDST:
        begin
          if (mem_ack)
          begin
            mem_we_reg    <= 1'b1;
            mem_wdata_reg <= {8'h00, bcd_diff};
            borrow_reg    <= bcd_borrow;
            nonzero_reg   <= nonzero_reg | (bcd_diff != 8'h00);
            state_reg     <= ST_WRDST;
          end
        end
        ST_WRDST:
        begin
          if (mem_ack)
          begin
            mem_we_reg     <= 1'b0;
            byte_idx_reg   <= idx_next;
            bytes_left_reg <= bytes_left_reg - 8'h01;
            if (bytes_left_reg == 8'h01)
            begin
              // Only carry and zero carry meaning after a string op
              mem_req_reg           <= 1'b0;
              flags_reg[FLG_CARRY]  <= borrow_reg;
              flags_reg[FLG_ZERO]   <= ~nonzero_reg;
              state_reg             <= ST_IDLE;
            end
            else
            begin
              mem_addr_reg <= phys_addr(src_seg, six_reg + idx_next);
              state_reg    <= ST_RDSRC;
            end
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Leaving a busy state this cycle
  wire logic state_done = ((state_reg == ST_SHIFT) & (steps_reg == 8'h01)) |
                          ((state_reg == ST_STORE) & mem_ack) |
                          ((state_reg == ST_WRDST) & mem_ack & (bytes_left_reg == 8'h01));

  logic busy_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_reg <= 1'b0;
    else
      busy_reg <= start | ((state_reg != ST_IDLE) & ~state_done);
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign mem_req   = mem_req_reg;
  assign mem_we    = mem_we_reg;
  assign mem_addr  = mem_addr_reg;
  assign mem_be    = mem_be_reg;
  assign mem_wdata = mem_wdata_reg;
  assign busy      = busy_reg;

endmodule // sssx_exec

// [hdl/sssx_pkg.sv]
package sssx_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets (APB, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DST_OPND  = 8'h04;
  localparam logic [7:0] OFS_SRC_OPND  = 8'h08;
  localparam logic [7:0] OFS_COUNT     = 8'h0c;
  localparam logic [7:0] OFS_ACCUM     = 8'h10;
  localparam logic [7:0] OFS_SRC_INDEX = 8'h14;
  localparam logic [7:0] OFS_DST_PTR   = 8'h18;
  localparam logic [7:0] OFS_DSEG      = 8'h1c;
  localparam logic [7:0] OFS_XSEG      = 8'h20;
  localparam logic [7:0] OFS_OVERRIDE  = 8'h24;
  localparam logic [7:0] OFS_STATUS    = 8'h28;
  localparam logic [7:0] OFS_RESULT    = 8'h2c;

  // ---------------------------------------------------------------
  // Control word fields
  // ---------------------------------------------------------------
  localparam int CTRL_OP_LSB    = 0;   // 3-bit operation code
  localparam int CTRL_WIDE      = 3;   // 1: word operand, 0: byte
  localparam int CTRL_FORM_LSB  = 4;   // 2-bit block store form
  localparam int CTRL_START     = 8;   // Write 1 to launch
  localparam int OVR_ENABLE     = 16;  // Segment override enable bit

  localparam logic [2:0] OP_LSHIFT = 3'h0;
  localparam logic [2:0] OP_ASHIFT = 3'h1;
  localparam logic [2:0] OP_SUB    = 3'h2;
  localparam logic [2:0] OP_BORROW_DIFFERENCE_OP   = 3'h3;
  localparam logic [2:0] OP_STORE  = 3'h4;
  localparam logic [2:0] OP_DECSUB = 3'h5;

  localparam logic [1:0] FORM_GENERIC = 2'h0;
  localparam logic [1:0] FORM_BYTES   = 2'h1;
  localparam logic [1:0] FORM_WORDS   = 2'h2;

  // ---------------------------------------------------------------
  // Status word: flags in the low 12 bits, busy above them
  // ---------------------------------------------------------------
  localparam int FLG_CARRY    = 0;
  localparam int FLG_PARITY   = 2;
  localparam int FLG_AUX      = 4;
  localparam int FLG_ZERO     = 6;
  localparam int FLG_SIGN     = 7;
  localparam int FLG_DIR      = 10;
  localparam int FLG_OVERFLOW = 11;
  localparam int STAT_BUSY    = 16;

  localparam logic [11:0] FLAGS_RST = 12'h000;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_STORE = 3'b010,
    ST_RDSRC = 3'b011,
    ST_RDDST = 3'b100,
    ST_WRDST = 3'b101
  } sssx_state_e;

endpackage

// [hdl/sssx_shift_step.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// One-place right shift, logical or sign-filling, byte or word
// ---------------------------------------------------------------
module sssx_shift_step (
  // Operand
  input  wire logic [15:0] value_in,
  input  wire logic        wide,
  input  wire logic        sign_fill,
  // Result
  output logic      [15:0] value_out,
  output logic             bit_out
);

  wire logic top_in = sign_fill & (wide ? value_in[15] : value_in[7]);

  // Top bit is zero or the old sign; bit 0 leaves towards carry
  assign value_out = wide ? {top_in, value_in[15:1]} : {8'h00, top_in, value_in[7:1]};
  assign bit_out   = value_in[0];

endmodule // sssx_shift_step

// [tb/sssx_chk.sv]
`timescale 1ns/1ps
// ----
// Port checks
// ----
module sssx_chk (
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Memory port, status
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [1:0]  mem_be,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase, then an access to an unmapped word
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_acc_s;
    setup_s ##1 (penable && (paddr > 8'h2c || paddr[1:0] != 2'h0));
  endsequence
  apb_ready_a: assert property (setup_s |=> pready) else $error("pready missing");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_qual_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  unmapped_a: assert property (bad_acc_s |-> pslverr) else $error("pslverr missing");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("req dropped");
  mem_busy_a: assert property (mem_req |-> busy) else $error("req while idle");
  store_lane_a: assert property (mem_req && mem_we |-> (mem_be == 2'h1 || mem_be == 2'h3)) else $error("lanes");
endmodule // sssx_chk
bind sssx_exec sssx_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata, .busy);

// [tb/sssx_mem.sv]
`timescale 1ns/1ps
// ----
// Operand memory model
// ----
module sssx_mem (
  // Clock, reset, pace
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        slow,
  // Request and answer
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [1:0]  mem_be,
  input wire logic [15:0] mem_wdata,
  output logic            mem_ack,
  output logic     [15:0] mem_rdata
);
  logic [7:0] m [0:65535];
  logic [1:0] wait_cnt;
  initial for (int i = 0; i < 65536; i++) m[i] = 8'hee;
  // Answer at once or after three idle cycles; outside an answer the data is scrambled
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= 16'h0;
    end
    else if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h3))
    begin
      mem_ack <= 1'b1;
      wait_cnt <= 2'h0;
      mem_rdata <= {m[mem_addr[15:0] + 16'h1], m[mem_addr[15:0]]};
      if (mem_we && mem_be[0]) m[mem_addr[15:0]] <= mem_wdata[7:0];
      if (mem_we && mem_be[1]) m[mem_addr[15:0] + 16'h1] <= mem_wdata[15:8];
    end
    else
    begin
      mem_ack <= 1'b0;
      wait_cnt <= mem_req ? wait_cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
endmodule // sssx_mem

// [tb/tb_shift_subtract_store_exec.sv]
`timescale 1ns/1ps
module tb_shift_subtract_store_exec;
  import sssx_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, mem_req, mem_we, mem_ack, busy, er;
  logic [19:0] mem_addr;
  logic [1:0] mem_be;
  logic [15:0] mem_wdata, mem_rdata;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #5 pclk = ~pclk;
  sssx_exec DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata, .busy);
  sssx_mem u_mem (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
    .mem_ack, .mem_rdata);
  // Hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Launch and poll busy; the last status read stays in rd
  task op_run(input logic [2:0] op, input logic wd, input logic [1:0] fm);
    int n;
    apb(1'b1, OFS_CTRL, {23'h0, 1'b1, 2'h0, fm, wd, op});
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[STAT_BUSY] !== 1'b0 && n < 400);
    if (rd[STAT_BUSY] !== 1'b0) chk({31'h0, rd[STAT_BUSY]}, 32'h0);
  endtask
  task alu(input logic [2:0] op, input logic wd, input logic [15:0] d, input logic [15:0] s,
           input logic [11:0] fi, input logic [15:0] r, input logic [11:0] fo);
    apb(1'b1, OFS_DST_OPND, 32'(d));
    apb(1'b1, OFS_SRC_OPND, 32'(s));
    apb(1'b1, OFS_STATUS, 32'(fi));
    op_run(op, wd, FORM_GENERIC);
    chk(32'(rd[11:0]), 32'(fo));
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rd & (wd ? 32'hffff : 32'hff), 32'(r));
  endtask
  task store(input logic wd, input logic [1:0] fm, input logic [11:0] fl, input logic [15:0] a,
             input logic [15:0] v, input logic [15:0] ptr);
    apb(1'b1, OFS_STATUS, 32'(fl));
    op_run(OP_STORE, wd, fm);
    chk(32'(rd[11:0]), 32'(fl));
    chk({16'h0, u_mem.m[a + 16'h1], u_mem.m[a]}, 32'(v));
    apb(1'b0, OFS_DST_PTR, 32'h0);
    chk(rd, 32'(ptr));
  endtask
  task dec(input logic [15:0] dv, input logic [15:0] sv, input logic [7:0] cnt,
           input logic [15:0] rv, input logic [11:0] fo);
    {u_mem.m[16'h2021], u_mem.m[16'h2020]} = dv;
    {u_mem.m[16'h4001], u_mem.m[16'h4000]} = sv;
    apb(1'b1, OFS_COUNT, 32'(cnt));
    apb(1'b1, OFS_STATUS, 32'h0);
    op_run(OP_DECSUB, 1'b0, FORM_GENERIC);
    chk(32'(rd[11:0] & 12'h041), 32'(fo));
    chk({16'h0, u_mem.m[16'h2021], u_mem.m[16'h2020]}, 32'(rv));
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    alu(OP_LSHIFT, 1'b0, 16'h0081, 16'h1, 12'h000, 16'h0040, 12'h801);
    alu(OP_LSHIFT, 1'b1, 16'h8005, 16'h3, 12'h800, 16'h1000, 12'h805);
    alu(OP_ASHIFT, 1'b0, 16'h0081, 16'h1, 12'h800, 16'h00c0, 12'h085);
    alu(OP_ASHIFT, 1'b1, 16'h8006, 16'h2, 12'h000, 16'he001, 12'h081);
    alu(OP_SUB, 1'b0, 16'h0010, 16'h1, 12'h8c5, 16'h000f, 12'h014);
    alu(OP_SUB, 1'b1, 16'h8000, 16'h1, 12'h000, 16'h7fff, 12'h814);
    alu(OP_SUB, 1'b0, 16'h0055, 16'h55, 12'h801, 16'h0000, 12'h044);
    alu(OP_SUB, 1'b0, 16'h0000, 16'h1, 12'h000, 16'h00ff, 12'h095);
    alu(OP_BORROW_DIFFERENCE_OP, 1'b1, 16'h0000, 16'h0, 12'h001, 16'hffff, 12'h095);
    apb(1'b1, OFS_ACCUM, 32'h1234);
    apb(1'b1, OFS_DST_PTR, 32'h10);
    apb(1'b1, OFS_XSEG, 32'h200);
    apb(1'b1, OFS_DSEG, 32'h300);
    apb(1'b1, OFS_OVERRIDE, 32'h1_0400);
    slow <= 1'b1;
    store(1'b0, FORM_GENERIC, 12'h0c5, 16'h2010, 16'hee34, 16'h0011);
    store(1'b0, FORM_WORDS, 12'h4c5, 16'h2011, 16'h1234, 16'h000f);
    store(1'b1, FORM_BYTES, 12'h4c5, 16'h200f, 16'h3434, 16'h000e);
    slow <= 1'b0;
    apb(1'b1, OFS_SRC_INDEX, 32'h0);
    apb(1'b1, OFS_DST_PTR, 32'h20);
    dec(16'h0100, 16'h0001, 8'd4, 16'h0099, 12'h000);
    dec(16'h0000, 16'h0001, 8'd3, 16'h9999, 12'h001);
    dec(16'h1234, 16'h1234, 8'd1, 16'h1200, 12'h040);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h05, 32'hffff);
    chk({31'h0, er}, 32'h1);
    complete_run();
  end
endmodule // tb_shift_subtract_store_exec
